// ---- include/ldcfg_pkg.sv ----
// ============================================================
// shared constants and carriers for the configuration bank
package ldcfg_pkg;

	// bank geometry
	localparam int N_DEV     = 7;
	localparam int N_SLOT    = 8;
	localparam int MEM_AW    = 7;
	localparam int MEM_DW    = 8;
	localparam int MEM_DEPTH = 128;

	// configuration indexes
	localparam logic [7:0] IDX_SELECTOR   = 8'h07;
	localparam logic [7:0] IDX_GLOBAL_LO  = 8'h20;
	localparam logic [7:0] IDX_GLOBAL_HI  = 8'h2F;
	localparam logic [7:0] IDX_BANKED_LO  = 8'h30;
	localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
	localparam logic [7:0] IDX_BASE0_HIGH = 8'h60;
	localparam logic [7:0] IDX_BASE0_LOW  = 8'h61;
	localparam logic [7:0] IDX_BASE1_HIGH = 8'h62;
	localparam logic [7:0] IDX_BASE1_LOW  = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUMBER = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE   = 8'h71;
	localparam logic [7:0] IDX_DMA0       = 8'h74;
	localparam logic [7:0] IDX_DMA1       = 8'h75;
	localparam logic [7:0] IDX_VENDOR_LO  = 8'hF0;
	localparam logic [7:0] IDX_VENDOR_HI  = 8'hFE;

	// assigned device numbers, slot 0 in the low byte
	localparam logic [N_DEV*8-1:0] DEV_NUMBERS =
		{8'h12, 8'h11, 8'h10, 8'h0F, 8'h06, 8'h05, 8'h04};

	// slot code for an unassigned selector and for the shared area
	localparam logic [2:0] NO_SLOT     = 3'h7;
	localparam logic [2:0] GLOBAL_SLOT = 3'h7;

	// field positions
	localparam int ACT_BIT   = 0;
	localparam int WAKE_BIT  = 4;
	localparam int POL_BIT   = 1;
	localparam int LEVEL_BIT = 0;

	// reset values
	localparam logic [7:0]  SELECTOR_RESET = 8'h00;
	localparam logic [2:0]  DMA_NONE       = 3'h4;
	localparam logic [15:0] BASE_RESET     = 16'h0000;
	localparam logic [3:0]  IRQ_NUM_RESET  = 4'h0;

	// one host access to the data port, index already latched
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} cfg_req_t;

	// one logical device's standard configuration
	typedef struct packed {
		logic        active;
		logic [15:0] base0;
		logic [15:0] base1;
		logic [3:0]  irq_num;
		logic        wake_en;
		logic        irq_pol;
		logic        irq_level;
		logic [2:0]  dma0;
		logic [2:0]  dma1;
	} dev_cfg_t;

	localparam dev_cfg_t CFG_RESET = '{
		active:    1'b0,
		base0:     BASE_RESET,
		base1:     BASE_RESET,
		irq_num:   IRQ_NUM_RESET,
		wake_en:   1'b0,
		irq_pol:   1'b0,
		irq_level: 1'b0,
		dma0:      DMA_NONE,
		dma1:      DMA_NONE
	};

endpackage : ldcfg_pkg

// ---- hdl/ldcfg_mem.sv ----
`timescale 1ns/100ps
// ============================================================
// byte store for vendor and shared registers, registered read
module ldcfg_mem (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          wr_en,
	input  wire logic [ldcfg_pkg::MEM_AW-1:0]  wr_addr,
	input  wire logic [ldcfg_pkg::MEM_DW-1:0]  wr_data,
	input  wire logic                          rd_en,
	input  wire logic [ldcfg_pkg::MEM_AW-1:0]  rd_addr,
	output      logic [ldcfg_pkg::MEM_DW-1:0]  rd_data
);
	import ldcfg_pkg::*;

	logic [MEM_DW-1:0] store [MEM_DEPTH];

	// write port, no reset on the array itself
	always_ff @(posedge clock) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	// read port, data out of a register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= store[rd_addr];
		end
	end

endmodule : ldcfg_mem

// ---- hdl/logical_device_config_bank.sv ----
`timescale 1ns/100ps
// Behaviour
// - selector chooses which device bank is accessed
// - all bank registers are host readable/writable
// - reserved bits read back as zero
// - indexes 20-2F are shared global registers
// - activate bit 0 enables selected block
// - base 0 high at 60, low at 61
// - base 1 high at 62, low at 63
// - irq bits 3-0 pick line, zero disables
// - irq bit 4 enables wake on request
// - type bit 1 sets request polarity
// - type bit 0 picks edge or level
// - dma 0 picks channel 0-3, 4 none
// - dma 1 same encoding as dma 0
// - indexes F0-FE hold vendor registers per device
// - index 30 and up reaches selected bank
// - unimplemented writes ignored, reads zero, dma four
// - inactive device's resources stay unused
module logical_device_config_bank (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire ldcfg_pkg::cfg_req_t             cfg_req,
	output      logic [7:0]                      rd_data,
	output      logic                            rd_valid,
	input  wire logic [ldcfg_pkg::N_DEV-1:0]     dev_irq,
	output      ldcfg_pkg::dev_cfg_t [ldcfg_pkg::N_DEV-1:0] dev_res,
	output      logic [15:0]                     host_irq,
	output      logic                            wake_event,
	output      logic                            bank_valid
);
	import ldcfg_pkg::*;

	// ========================================================
	// decoding helpers

	// selector value to bank slot, top bit flags a known device
	function automatic logic [3:0] slot_of(input logic [7:0] sel);
		logic [3:0] r;
		r = {1'b0, NO_SLOT};
		for (int i = 0; i < N_DEV; i++) begin
			if (sel == DEV_NUMBERS[i*8 +: 8]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : slot_of

	// inclusive index range test
	function automatic logic in_range(
		input logic [7:0] idx,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		return (idx >= lo) && (idx <= hi);
	endfunction : in_range

	// read view of a standard register, reserved bits zero
	function automatic logic [7:0] read_std(
		input dev_cfg_t   c,
		input logic [7:0] idx
	);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			IDX_ACTIVATE:   r[ACT_BIT] = c.active;
			IDX_BASE0_HIGH: r = c.base0[15:8];
			IDX_BASE0_LOW:  r = c.base0[7:0];
			IDX_BASE1_HIGH: r = c.base1[15:8];
			IDX_BASE1_LOW:  r = c.base1[7:0];
			IDX_IRQ_NUMBER: begin
				r[3:0]      = c.irq_num;
				r[WAKE_BIT] = c.wake_en;
			end
			IDX_IRQ_TYPE: begin
				r[POL_BIT]   = c.irq_pol;
				r[LEVEL_BIT] = c.irq_level;
			end
			IDX_DMA0: r[2:0] = c.dma0;
			IDX_DMA1: r[2:0] = c.dma1;
			default:  r = 8'h00;
		endcase
		return r;
	endfunction : read_std

	// new standard register contents after a host write
	function automatic dev_cfg_t apply_write(
		input dev_cfg_t   c,
		input logic [7:0] idx,
		input logic [7:0] d
	);
		dev_cfg_t r;
		r = c;
		case (idx)
			IDX_ACTIVATE:   r.active = d[ACT_BIT];
			IDX_BASE0_HIGH: r.base0[15:8] = d;
			IDX_BASE0_LOW:  r.base0[7:0] = d;
			IDX_BASE1_HIGH: r.base1[15:8] = d;
			IDX_BASE1_LOW:  r.base1[7:0] = d;
			IDX_IRQ_NUMBER: begin
				r.irq_num = d[3:0];
				r.wake_en = d[WAKE_BIT];
			end
			IDX_IRQ_TYPE: begin
				r.irq_pol   = d[POL_BIT];
				r.irq_level = d[LEVEL_BIT];
			end
			IDX_DMA0: r.dma0 = d[2:0];
			IDX_DMA1: r.dma1 = d[2:0];
			default:  r = c;
		endcase
		return r;
	endfunction : apply_write

	// ========================================================
	// access decode

	logic [7:0]                selector;
	dev_cfg_t [N_SLOT-1:0]     cfg_all;
	logic [MEM_DEPTH-1:0]      mem_written;
	logic [MEM_DW-1:0]         mem_q;
	logic [7:0]                rd_hold;
	logic                      rd_use_mem;
	logic                      rd_mem_ok;
	logic                      rd_stage;
	logic [N_DEV-1:0]          irq_prev;
	logic [N_DEV-1:0]          slot_req;

	wire logic [7:0] idx = cfg_req.index;
	wire logic [7:0] wdat = cfg_req.wdata;

	// bank selection from the selector
	wire logic [3:0] sel_dec  = slot_of(selector);
	wire logic       dev_ok   = sel_dec[3];
	wire logic [2:0] dev_slot = sel_dec[2:0];

	// index classes
	wire logic is_sel    = (idx == IDX_SELECTOR);
	wire logic is_global = in_range(idx, IDX_GLOBAL_LO, IDX_GLOBAL_HI);
	wire logic is_vendor = in_range(idx, IDX_VENDOR_LO, IDX_VENDOR_HI);
	wire logic is_banked = (idx >= IDX_BANKED_LO);

	// write strobes, unknown device writes are dropped
	wire logic wr_sel = cfg_req.wr && is_sel;
	wire logic wr_std = cfg_req.wr && is_banked && !is_vendor && dev_ok;
	wire logic wr_mem = cfg_req.wr && (is_global || (is_vendor && dev_ok));

	// memory addressing, slot 7 holds the shared area
	wire logic [MEM_AW-1:0] mem_addr = is_global
		? {GLOBAL_SLOT, idx[3:0]}
		: {dev_slot, idx[3:0]};
	wire logic rd_mem = cfg_req.rd && (is_global || (is_vendor && dev_ok));

	// current bank, slot 7 reads as defaults
	wire dev_cfg_t cur_cfg   = cfg_all[dev_slot];
	wire dev_cfg_t next_cfg  = apply_write(cur_cfg, idx, wdat);
	wire logic [7:0] std_val = read_std(cur_cfg, idx);

	// first-stage read value for register-held indexes
	wire logic [7:0] next_hold = is_sel ? selector
		: (is_banked && !is_vendor) ? std_val
		: 8'h00;

	// ========================================================
	// selector register

	// written through the data port at index 07
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			selector <= SELECTOR_RESET;
		end else if (wr_sel) begin
			selector <= wdat;
		end
	end

	// ========================================================
	// per-device standard registers

	assign cfg_all[NO_SLOT] = CFG_RESET;

	genvar g;
	generate
		for (g = 0; g < N_DEV; g++) begin : g_dev
			dev_cfg_t store;
			dev_cfg_t res_q;
			logic     edge_seen;

			// one bank per device, touched only when selected
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					store <= CFG_RESET;
				end else if (wr_std && dev_slot == 3'(g)) begin
					store <= next_cfg;
				end
			end
			assign cfg_all[g] = store;

			// request as the host line sees it, edge or level
			assign edge_seen = dev_irq[g] && !irq_prev[g];
			assign slot_req[g] = store.irq_level
				? dev_irq[g] : edge_seen;

			// resources published only while active
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					res_q <= CFG_RESET;
				end else begin
					res_q <= store.active ? store : CFG_RESET;
				end
			end
			assign dev_res[g] = res_q;
		end
	endgenerate

	// ========================================================
	// interrupt routing and wake-up

	logic [15:0] line_req;
	logic [15:0] line_low;
	logic [15:0] next_host_irq;
	logic        next_wake;

	// collect requests per host line, polarity from owners
	always_comb begin
		line_req  = 16'h0000;
		line_low  = 16'h0000;
		next_wake = 1'b0;
		for (int i = 0; i < N_DEV; i++) begin
			if (cfg_all[i].active && cfg_all[i].irq_num != 4'h0) begin
				line_req[cfg_all[i].irq_num] =
					line_req[cfg_all[i].irq_num] || slot_req[i];
				line_low[cfg_all[i].irq_num] =
					line_low[cfg_all[i].irq_num]
					|| !cfg_all[i].irq_pol;
			end
			if (cfg_all[i].active && cfg_all[i].wake_en
				&& dev_irq[i] && !irq_prev[i]) begin
				next_wake = 1'b1;
			end
		end
		next_host_irq = line_req ^ line_low;
	end

	// line drivers and wake pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_prev   <= '0;
			host_irq   <= 16'h0000;
			wake_event <= 1'b0;
		end else begin
			irq_prev   <= dev_irq;
			host_irq   <= next_host_irq;
			wake_event <= next_wake;
		end
	end

	// ========================================================
	// vendor and shared byte store

	ldcfg_mem u_mem (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (wr_mem),
		.wr_addr (mem_addr),
		.wr_data (wdat),
		.rd_en   (rd_mem),
		.rd_addr (mem_addr),
		.rd_data (mem_q)
	);

	// written-once flags so unwritten bytes read as reset zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_written <= '0;
		end else if (wr_mem) begin
			mem_written[mem_addr] <= 1'b1;
		end
	end

	// ========================================================
	// read pipeline, answer two edges after the request

	// first stage, mux and memory flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_stage   <= 1'b0;
			rd_hold    <= 8'h00;
			rd_use_mem <= 1'b0;
			rd_mem_ok  <= 1'b0;
		end else begin
			rd_stage   <= cfg_req.rd;
			rd_hold    <= next_hold;
			rd_use_mem <= rd_mem;
			rd_mem_ok  <= mem_written[mem_addr];
		end
	end

	// second stage, data and strobe to the port
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_stage;
			if (rd_stage) begin
				rd_data <= rd_use_mem
					? (rd_mem_ok ? mem_q : 8'h00)
					: rd_hold;
			end
		end
	end

	// selector status for the index/data port logic
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bank_valid <= 1'b0;
		end else begin
			bank_valid <= dev_ok;
		end
	end

	// host side keeps reserved bits by read-modify-write
	// write-only registers are not read back first

endmodule : logical_device_config_bank

// ---- dv/ldcfg_assertions.sv ----
`timescale 1ns/100ps
// ============================================================
// port checker for the configuration bank
module ldcfg_checker (
	input wire logic                                    clock,
	input wire logic                                    rst,
	input wire ldcfg_pkg::cfg_req_t                     cfg_req,
	input wire logic [7:0]                              rd_data,
	input wire logic                                    rd_valid,
	input wire logic [ldcfg_pkg::N_DEV-1:0]             dev_irq,
	input wire ldcfg_pkg::dev_cfg_t [ldcfg_pkg::N_DEV-1:0] dev_res,
	input wire logic [15:0]                             host_irq,
	input wire logic                                    wake_event,
	input wire logic                                    bank_valid
);
	import ldcfg_pkg::*;

	logic [N_DEV-1:0] irq_q;
	logic [N_DEV-1:0] act;
	logic [N_DEV-1:0] wk;
	logic             inert_ok;
	wire              wake_cause = |(dev_irq & ~irq_q & act & wk);

	// per-slot view of the published configuration
	always_comb begin
		inert_ok = 1'b1;
		for (int i = 0; i < N_DEV; i++) begin
			act[i] = dev_res[i].active;
			wk[i] = dev_res[i].wake_en;
			if (!act[i] && dev_res[i] != CFG_RESET)
				inert_ok = 1'b0;
		end
	end

	// previous request levels, for rising edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			irq_q <= '0;
		else
			irq_q <= dev_irq;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// ============================================================
	// properties
	rd_latency_a: assert property (cfg_req.rd |-> ##2 rd_valid)
		else $error("read answer late");
	rd_cause_a: assert property (rd_valid |-> $past(cfg_req.rd, 2))
		else $error("answer without read");
	rd_hold_a: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data moved");
	line_zero_a: assert property (host_irq[0] == 1'b0)
		else $error("line zero driven");
	inert_res_a: assert property (inert_ok)
		else $error("inactive slot shows resources");
	idle_lines_a: assert property (act == '0 |-> host_irq == 16'h0000)
		else $error("line driven with no active slot");
	wake_go_a: assert property (wake_cause |=> wake_event)
		else $error("wake missing");
	wake_src_a: assert property (wake_event |-> $past(wake_cause))
		else $error("wake without cause");
	sel_valid_a: assert property (cfg_req.wr && cfg_req.index == IDX_SELECTOR
		&& cfg_req.wdata == 8'h04 |-> ##2 bank_valid)
		else $error("assigned selector not valid");
	sel_none_a: assert property (cfg_req.wr && cfg_req.index == IDX_SELECTOR
		&& cfg_req.wdata == 8'h00 |-> ##2 !bank_valid)
		else $error("reserved selector valid");

	cover property (rd_valid);
	cover property (wake_event);
	cover property (host_irq[3]);
endmodule : ldcfg_checker

bind logical_device_config_bank ldcfg_checker i_chk (
	.clock(clock), .rst(rst), .cfg_req(cfg_req), .rd_data(rd_data),
	.rd_valid(rd_valid), .dev_irq(dev_irq), .dev_res(dev_res),
	.host_irq(host_irq), .wake_event(wake_event), .bank_valid(bank_valid)
);

// ---- dv/ldcfg_host.sv ----
`timescale 1ns/100ps
// ============================================================
// host side of the data port
module ldcfg_host (
	input  wire logic                clock,
	output      ldcfg_pkg::cfg_req_t req,
	input  wire logic [7:0]          rd_data,
	input  wire logic                rd_valid
);
	import ldcfg_pkg::*;

	initial req = '0;

	// plain write, left standing so a next access follows at once
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		req <= '{1'b1, 1'b0, i, d};
		@(posedge clock);
	endtask : wr

	// read, bounded wait for the answer
	task automatic rd(input logic [7:0] i, output logic [7:0] d);
		req <= '{1'b0, 1'b1, i, 8'h00};
		@(posedge clock);
		req <= '0;
		for (int n = 0; n < 8; n++) begin
			@(posedge clock);
			if (rd_valid === 1'b1) begin
				d = rd_data;
				return;
			end
		end
		logical_device_config_bank_test.bad_count++;
		logical_device_config_bank_test.end_sim();
	endtask : rd

	// release the port
	task automatic idle();
		req <= '0;
		@(posedge clock);
	endtask : idle
endmodule : ldcfg_host

// ---- dv/logical_device_config_bank_test.sv ----
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the configuration bank
module logical_device_config_bank_test;
	import ldcfg_pkg::*;

	logic                 clock = 1'b0;
	logic                 rst = 1'b1;
	cfg_req_t             cfg_req;
	logic [7:0]           rd_data;
	logic                 rd_valid;
	logic [N_DEV-1:0]     dev_irq = '0;
	dev_cfg_t [N_DEV-1:0] dev_res;
	logic [15:0]          host_irq;
	logic                 wake_event;
	logic                 bank_valid;
	int                   bad_count = 0;
	int                   n_checks = 0;
	logic [31:0]          seed = 32'h7FA2;
	logic [7:0]           sel;
	logic [7:0]           mem [0:7][0:255];
	logic [7:0]           v;

	always #4 clock = ~clock;

	logical_device_config_bank i_dut (
		.clock(clock), .rst(rst), .cfg_req(cfg_req), .rd_data(rd_data),
		.rd_valid(rd_valid), .dev_irq(dev_irq), .dev_res(dev_res),
		.host_irq(host_irq), .wake_event(wake_event), .bank_valid(bank_valid)
	);

	ldcfg_host i_host (
		.clock(clock), .req(cfg_req), .rd_data(rd_data), .rd_valid(rd_valid)
	);

	// ============================================================
	// expectation model
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] rmask(input logic [7:0] i);
		if (i == IDX_ACTIVATE) return 8'h01;
		if (i >= IDX_BASE0_HIGH && i <= IDX_BASE1_LOW) return 8'hFF;
		if (i == IDX_IRQ_NUMBER) return 8'h1F;
		if (i == IDX_IRQ_TYPE) return 8'h03;
		if (i == IDX_DMA0 || i == IDX_DMA1) return 8'h07;
		if (i >= IDX_VENDOR_LO && i <= IDX_VENDOR_HI) return 8'hFF;
		return 8'h00;
	endfunction : rmask

	function automatic logic [2:0] slot(input logic [7:0] s);
		for (int k = 0; k < N_DEV; k++)
			if (DEV_NUMBERS[k*8 +: 8] == s) return 3'(k);
		return NO_SLOT;
	endfunction : slot

	function automatic logic [7:0] mrd(input logic [7:0] i);
		if (i == IDX_SELECTOR) return sel;
		if (i >= IDX_GLOBAL_LO && i <= IDX_GLOBAL_HI) return mem[7][i];
		if (i < IDX_BANKED_LO) return 8'h00;
		if (slot(sel) == NO_SLOT) return (rmask(i) == 8'h07) ? 8'h04 : 8'h00;
		return mem[slot(sel)][i];
	endfunction : mrd

	function automatic dev_cfg_t eres(input int s);
		dev_cfg_t c;
		c = CFG_RESET;
		if (mem[s][8'h30][0])
			c = '{1'b1, {mem[s][8'h60], mem[s][8'h61]},
				{mem[s][8'h62], mem[s][8'h63]}, mem[s][8'h70][3:0],
				mem[s][8'h70][4], mem[s][8'h71][1], mem[s][8'h71][0],
				mem[s][8'h74][2:0], mem[s][8'h75][2:0]};
		return c;
	endfunction : eres

	// ============================================================
	// checking and access tasks
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic mreset();
		sel = SELECTOR_RESET;
		for (int s = 0; s < 8; s++)
			for (int i = 0; i < 256; i++)
				mem[s][i] = (rmask(8'(i)) == 8'h07) ? 8'h04 : 8'h00;
	endtask : mreset

	task automatic put(input logic [7:0] i, input logic [7:0] d);
		i_host.wr(i, d);
		if (i == IDX_SELECTOR)
			sel = d;
		else if (i >= IDX_GLOBAL_LO && i <= IDX_GLOBAL_HI)
			mem[7][i] = d;
		else if (i >= IDX_BANKED_LO && slot(sel) != NO_SLOT)
			mem[slot(sel)][i] = d & rmask(i);
	endtask : put

	task automatic get(input logic [7:0] i);
		i_host.rd(i, v);
		check(v, mrd(i));
	endtask : get

	// every slot's outputs, then every index of every bank
	task automatic sweep();
		i_host.idle();
		repeat (2) @(posedge clock);
		for (int s = 0; s < N_DEV; s++)
			check(64'(dev_res[s]), 64'(eres(s)));
		for (int s = 0; s < N_DEV; s++) begin
			put(IDX_SELECTOR, DEV_NUMBERS[s*8 +: 8]);
			for (int i = 0; i < 256; i++)
				get(8'(i));
			check(bank_valid, 1'b1);
		end
	endtask : sweep

	// ============================================================
	// main sequence
	initial begin
		mreset();
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		sweep();
		// reserved selector: bank inert, dma reads four
		put(IDX_SELECTOR, 8'h00);
		get(IDX_DMA1);
		check(bank_valid, 1'b0);
		repeat (600) begin
			seed = lfsr(seed);
			v = seed[15:8];
			case (seed[1:0])
				2'd0: put(IDX_SELECTOR, (seed[4:2] < 3'd7) ?
					DEV_NUMBERS[seed[4:2]*8 +: 8] : seed[23:16]);
				2'd1: put(v, seed[23:16]);
				2'd2: get(v);
				default: begin
					put(v, seed[23:16]);
					get(v);
				end
			endcase
		end
		sweep();
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		mreset();
		sweep();
		// slot 0 on line 3, level, low polarity, wake on
		put(IDX_SELECTOR, DEV_NUMBERS[7:0]);
		put(IDX_ACTIVATE, 8'h01);
		put(IDX_IRQ_TYPE, 8'h01);
		get(IDX_IRQ_NUMBER);
		put(IDX_IRQ_NUMBER, v | 8'h13);
		i_host.idle();
		repeat (3) @(posedge clock);
		repeat (60) begin
			seed = lfsr(seed);
			dev_irq <= seed[6:0];
			repeat (2) @(posedge clock);
			check(host_irq, seed[0] ? 16'h0000 : 16'h0008);
		end
		// edge type, high polarity: one pulse per rise
		dev_irq <= '0;
		put(IDX_IRQ_TYPE, 8'h02);
		i_host.idle();
		repeat (3) @(posedge clock);
		dev_irq <= 7'h01;
		repeat (2) @(posedge clock);
		check(host_irq, 16'h0008);
		check(wake_event, 1'b1);
		@(posedge clock);
		check(host_irq, 16'h0000);
		check(wake_event, 1'b0);
		end_sim();
	end
endmodule : logical_device_config_bank_test
